//--- hdl/sbsc_core.sv
// control input front end and storage of the burst memory
`timescale 1ns/10ps
`include "sbsc_params.svh"
module sbsc_core
    import sbsc_pkg::*;
#(
    parameter int ADDR_W = `SBSC_ADDR_W,
    parameter int LANES  = `SBSC_LANES,
    parameter int DEPTH  = `SBSC_DEPTH
) (
    input  wire logic              clk,
    input  wire logic              reset_n,
    input  wire logic [ADDR_W-1:0] address,
    input  wire logic [LANES-1:0]  byte_lane_write_select_n,
    input  wire logic              write_enable_n,
    input  wire logic              advance_or_load,
    input  wire logic              clock_qualifier_n,
    input  wire logic              chip_select_one_n,
    input  wire logic              chip_select_two,
    input  wire logic              chip_select_three_n,
    input  wire logic              burst_mode,
    input  wire logic [LANES*8-1:0] data_in,
    input  wire logic [LANES-1:0]  parity_lane_in,
    output logic      [LANES*8-1:0] data_out,
    output logic      [LANES-1:0]  parity_lane_out,
    output logic                   data_oe,
    output logic                   write_active
);
    localparam int IDX_W = $clog2(DEPTH);

    // ****************************************
    // pin synchronisers
    // ****************************************
    localparam int SW = ADDR_W + LANES + 6 + LANES*9;
    logic [SW-1:0] s1_r, s2_r;
    always_ff @(posedge clk) begin
        s1_r <= {address, byte_lane_write_select_n, write_enable_n,
                 advance_or_load, clock_qualifier_n, chip_select_one_n,
                 chip_select_two, chip_select_three_n, data_in,
                 parity_lane_in};
        s2_r <= s1_r;
    end
    logic [ADDR_W-1:0]  a_s;
    logic [LANES-1:0]   bw_s, par_s;
    logic               we_s, adv_s, cq_s, c1_s, c2_s, c3_s;
    logic [LANES*8-1:0] d_s;
    assign {a_s, bw_s, we_s, adv_s, cq_s, c1_s, c2_s, c3_s, d_s, par_s}
        = s2_r;
    logic [1:0] mode_s_r;
    always_ff @(posedge clk) mode_s_r <= {mode_s_r[0], burst_mode};

    // ****************************************
    // access control
    // ****************************************
    sbsc_access_t acc_r, acc_nxt;
    logic [1:0]   base_r, base_nxt, cnt_r, cnt_nxt;
    logic         mode_r, mode_nxt;
    logic [LANES-1:0] wlane_r, wlane_nxt;
    logic         sel;
    assign sel = !c1_s && c2_s && !c3_s;
    always_comb begin
        acc_nxt   = acc_r;
        base_nxt  = base_r;
        cnt_nxt   = cnt_r;
        wlane_nxt = wlane_r;
        mode_nxt  = mode_r;
        if (!cq_s) begin
            if (!adv_s) begin
                mode_nxt = mode_s_r[1];
                cnt_nxt  = `SBSC_RST_BURST;
                base_nxt = a_s[1:0];
                acc_nxt.addr = a_s;
                wlane_nxt = ~bw_s;
                if (!sel)
                    acc_nxt.op = SBSC_IDLE;
                else if (!we_s)
                    acc_nxt.op = SBSC_WRITE;
                else
                    acc_nxt.op = SBSC_READ;
            end else if (acc_r.op != SBSC_IDLE) begin
                cnt_nxt = cnt_r + 2'h1;
                // keep op of last load; lanes follow this cycle
                wlane_nxt = ~bw_s;
                acc_nxt.addr[1:0] = mode_r ? (base_r ^ cnt_nxt)
                                           : (base_r + cnt_nxt);
            end
        end
    end
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            acc_r   <= '{addr: '0, op: SBSC_IDLE};
            base_r  <= `SBSC_RST_BURST;
            cnt_r   <= `SBSC_RST_BURST;
            wlane_r <= '0;
            mode_r  <= 1'b1;
        end else begin
            acc_r   <= acc_nxt;
            base_r  <= base_nxt;
            cnt_r   <= cnt_nxt;
            wlane_r <= wlane_nxt;
            mode_r  <= mode_nxt;
        end
    end

    // ****************************************
    // storage and data path
    // ****************************************
    logic [8:0] mem_r [LANES][DEPTH];
    logic [IDX_W-1:0] idx;
    assign idx = acc_r.addr[IDX_W-1:0];
    logic do_wr;
    assign do_wr = !cq_s && acc_r.op == SBSC_WRITE;
    // lane outermost so each lane process owns its own slice
    genvar g;
    generate
        for (g = 0; g < LANES; g++) begin : g_lane
            always_ff @(posedge clk) begin
                if (do_wr && wlane_r[g])
                    mem_r[g][idx] <= {par_s[g], d_s[g*8 +: 8]};
            end
        end
    endgenerate
    logic [LANES*8-1:0] dout_nxt;
    logic [LANES-1:0]   pout_nxt;
    logic               oe_nxt, wact_nxt;
    always_comb begin
        dout_nxt = data_out;
        pout_nxt = parity_lane_out;
        oe_nxt   = data_oe;
        wact_nxt = write_active;
        if (!cq_s) begin
            // drivers off for write data and deselected cycles
            oe_nxt   = acc_r.op == SBSC_READ;
            wact_nxt = acc_r.op == SBSC_WRITE;
            if (acc_r.op == SBSC_READ) begin
                for (int i = 0; i < LANES; i++) begin
                    dout_nxt[i*8 +: 8] = mem_r[i][idx][7:0];
                    pout_nxt[i]        = mem_r[i][idx][8];
                end
            end
        end
    end
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            data_out        <= '0;
            parity_lane_out <= '0;
            data_oe         <= 1'b0;
            write_active    <= 1'b0;
        end else begin
            data_out        <= dout_nxt;
            parity_lane_out <= pout_nxt;
            data_oe         <= oe_nxt;
            write_active    <= wact_nxt;
        end
    end

    // ****************************************
    // assertions
    // ****************************************
    sequence s_rd_load;
        !cq_s && !adv_s && sel && we_s;
    endsequence
    sequence s_wr_load;
        !cq_s && !adv_s && sel && !we_s;
    endsequence
    // access loaded, then its data cycle is a qualified edge
    sequence s_wr_data;
        s_wr_load ##1 !cq_s;
    endsequence
    sequence s_rd_data;
        s_rd_load ##1 !cq_s;
    endsequence
    AST_HOLD: assert property (@(posedge clk)
        disable iff (!reset_n)
        cq_s |=> $stable(acc_r) && $stable(cnt_r))
        else $error("state moved while clock qualifier high");
    AST_LOAD: assert property (@(posedge clk)
        disable iff (!reset_n)
        !cq_s && !adv_s |=> acc_r.addr == $past(a_s))
        else $error("load did not take address");
    AST_SEL: assert property (@(posedge clk)
        disable iff (!reset_n)
        !cq_s && !adv_s && !sel |=> acc_r.op == SBSC_IDLE)
        else $error("deselect not recognised");
    AST_WE: assert property (@(posedge clk)
        disable iff (!reset_n)
        !cq_s && !adv_s && sel |=>
        (acc_r.op == SBSC_WRITE) == !$past(we_s))
        else $error("write enable not sampled");
    AST_UPPER: assert property (@(posedge clk)
        disable iff (!reset_n)
        !cq_s && adv_s |=>
        acc_r.addr[ADDR_W-1:2] == $past(acc_r.addr[ADDR_W-1:2]))
        else $error("burst changed upper address");
    AST_OP: assert property (@(posedge clk)
        disable iff (!reset_n)
        adv_s |=> acc_r.op == $past(acc_r.op))
        else $error("burst changed op");
    AST_STEP: assert property (@(posedge clk)
        disable iff (!reset_n)
        !cq_s && adv_s && acc_r.op != SBSC_IDLE |=>
        cnt_r == $past(cnt_r) + 2'h1)
        else $error("burst counter did not step");
    AST_OE: assert property (@(posedge clk)
        disable iff (!reset_n)
        write_active |-> !data_oe)
        else $error("outputs driven in write");
    AST_WLANE: assert property (@(posedge clk)
        disable iff (!reset_n)
        !cq_s && !adv_s |=> wlane_r == ~$past(bw_s))
        else $error("lane selects not captured");
    AST_RD_OUT: assert property (@(posedge clk)
        disable iff (!reset_n)
        s_rd_data |=> data_oe && !write_active)
        else $error("read access did not drive outputs");
    AST_WR_OUT: assert property (@(posedge clk)
        disable iff (!reset_n)
        s_wr_data |=> write_active && !data_oe)
        else $error("outputs driven in write data phase");
    AST_HOLD_OUT: assert property (@(posedge clk)
        disable iff (!reset_n)
        cq_s |=> $stable(data_out) && $stable(parity_lane_out)
        && $stable(data_oe) && $stable(write_active))
        else $error("outputs moved while clock qualifier high");
    AST_MODE: assert property (@(posedge clk)
        disable iff (!reset_n)
        !cq_s && !adv_s |=> mode_r == $past(mode_s_r[1]))
        else $error("burst order not taken at load");
    AST_WR_MEM: assert property (@(posedge clk)
        disable iff (!reset_n)
        s_wr_data ##0 wlane_r[0] |=>
        mem_r[0][$past(idx)] == {$past(par_s[0]), $past(d_s[7:0])})
        else $error("selected lane not stored");
    AST_LIN_STEP: assert property (@(posedge clk)
        disable iff (!reset_n)
        !cq_s && adv_s && acc_r.op != SBSC_IDLE && !mode_r |=>
        acc_r.addr[1:0] == $past(acc_r.addr[1:0]) + 2'h1)
        else $error("linear burst did not step by one");
endmodule

//--- hdl/sbsc_params.svh
// constants for the synchronous burst memory control front end
//Contract
//- address captured on qualified rising edge
//- low lane select with write stores lane
//- write enable sampled only when qualifier low
//- advance high steps internal burst counter
//- clock recognised only while qualifier low
//- qualifier high holds all state and outputs
//- select needs cs1 low, cs2 high, cs3 low
//- data outputs released during write data phase
//- strap high interleaved, low linear, kept constant
`ifndef SBSC_PARAMS_SVH
`define SBSC_PARAMS_SVH
`define SBSC_ADDR_W     19
`define SBSC_LANES      4
`define SBSC_DEPTH      64
`define SBSC_RST_BURST  2'h0
`endif

//--- hdl/sbsc_pkg.sv
// types of the synchronous burst memory control front end
`include "sbsc_params.svh"
package sbsc_pkg;
    typedef enum logic [1:0] {
        SBSC_IDLE,
        SBSC_READ,
        SBSC_WRITE
    } sbsc_op_t;
    typedef struct packed {
        logic [`SBSC_ADDR_W-1:0] addr;
        sbsc_op_t                op;
    } sbsc_access_t;
endpackage

//--- hdl/sbsc_dummy_unused.sv
// intentionally empty
`timescale 1ns/10ps

//--- sim/sbsc_host_model.sv
// controller model that drives the memory pins
`timescale 1ns/10ps
module sbsc_host_model (
    input  wire logic   clk,
    output logic [18:0] adr,
    output logic [3:0]  bw_n,
    output logic        we_n,
    output logic        adv,
    output logic        cq_n,
    output logic [2:0]  sel,
    output logic [35:0] dat
);
    // one pin cycle; dat belongs to the previous load
    task automatic op(logic [2:0] s, logic q, w, v, logic [18:0] a,
                      logic [3:0] b, logic [35:0] d);
        sel = s;
        cq_n = q;
        we_n = w;
        adv = v;
        adr = a;
        bw_n = b;
        dat = d;
        @(negedge clk);
    endtask
    // deselected, released data lines show the inverse
    task automatic idle();
        op(3'b100, 1'b0, 1'b1, 1'b0, adr, 4'hf, ~dat);
    endtask
endmodule

//--- sim/test_sync_burst_sram_control_inputs.sv
// self-checking bench of the burst memory control front end
`timescale 1ns/10ps
module test_sync_burst_sram_control_inputs;
    logic clk, reset_n, mode, oe, wa, we_n, adv, cq_n;
    logic [18:0] adr, a;
    logic [3:0] bw_n, par;
    logic [2:0] sel;
    logic [35:0] dat, d, mem [64];
    logic [31:0] dout;
    int num_errors, tests_run, cyc;
    integer seed = 32'h6864_f1ab;
`define CHK(n, e, s) begin tests_run++; if ((s) !== (e)) begin \
num_errors++; $display("ERROR %s exp %h got %h", n, e, s); end end
    sbsc_host_model u_sbsc_host_model (.clk(clk), .adr(adr),
        .bw_n(bw_n), .we_n(we_n), .adv(adv), .cq_n(cq_n), .sel(sel),
        .dat(dat));
    sbsc_core u_sbsc_core (.clk(clk), .reset_n(reset_n), .address(adr),
        .byte_lane_write_select_n(bw_n), .write_enable_n(we_n),
        .advance_or_load(adv), .clock_qualifier_n(cq_n),
        .chip_select_one_n(sel[2]), .chip_select_two(sel[1]),
        .chip_select_three_n(sel[0]), .burst_mode(mode),
        .data_in(dat[31:0]), .parity_lane_in(dat[35:32]),
        .data_out(dout), .parity_lane_out(par), .data_oe(oe),
        .write_active(wa));
    function automatic logic [5:0] ba(logic [18:0] b, int k);
        return {b[5:2], mode ? b[1:0] ^ 2'(k) : b[1:0] + 2'(k)};
    endfunction
    function automatic logic [35:0] mrg(logic [35:0] o, n, logic [3:0] b);
        for (int i = 0; i < 4; i++) begin
            if (!b[i]) o[8*i +: 8] = n[8*i +: 8];
            if (!b[i]) o[32 + i] = n[32 + i];
        end
        return o;
    endfunction
    task automatic wr(logic [2:0] s, logic q, logic [3:0] b);
        u_sbsc_host_model.op(s, q, 1'b0, 1'b0, a, b, ~dat);
        u_sbsc_host_model.op(3'b100, q, 1'b1, 1'b0, a, b, d);
        if (s == 3'b010 && !q) mem[a[5:0]] = mrg(mem[a[5:0]], d, b);
    endtask
    task automatic rd(logic [5:0] x);
        u_sbsc_host_model.op(3'b010, 1'b0, 1'b1, 1'b0, 19'(x), 4'hf, ~dat);
        for (int n = 0; n < 12 && oe !== 1'b1; n++) u_sbsc_host_model.idle();
        `CHK("read", {1'b1, mem[x]}, {oe, par, dout})
        repeat (4) u_sbsc_host_model.idle();
    endtask
    task automatic complete_run();
        $display("checks %0d mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc++;
        if (cyc == 5000) num_errors++;
        if (cyc == 5000) complete_run();
    end
    initial begin
        reset_n = 1'b0;
        mode = 1'b1;
        u_sbsc_host_model.op(3'b100, 1'b0, 1'b1, 1'b0, '0, 4'hf, '0);
        repeat (1) u_sbsc_host_model.idle();
        reset_n = 1'b1;
        repeat (4) u_sbsc_host_model.idle();
        `CHK("reset", 38'h0, {oe, wa, par, dout})
        for (int i = 0; i < 80; i++) begin
            d = 36'({$random(seed), $random(seed)});
            a = 19'($random(seed));
            if (i < 64) a[5:0] = 6'(i);
            wr(3'b010, 1'b0, i < 64 ? 4'h0 : 4'($random(seed)));
            if (i >= 64) rd(a[5:0]);
        end
        $display("lane writes done");
        for (int s = 0; s < 9; s++) begin
            d = ~d;
            wr(s < 8 ? 3'(s) : 3'b010, s == 8, 4'h0);
            rd(a[5:0]);
        end
        $display("ignored writes done");
        for (int m = 0; m < 2; m++) begin
            mode = m[0];
            for (int k = 0; k < 5; k++) begin
                d = 36'({$random(seed), $random(seed)});
                if (k > 0) mem[ba(a, k - 1)] = d;
                u_sbsc_host_model.op(k == 4 ? 3'b100 : 3'b010, 1'b0, k == 4,
                                     k > 0 && k < 4, a, 4'h0, d);
            end
            `CHK("write phase", 2'b10, {wa, oe})
            u_sbsc_host_model.op(3'b010, 1'b0, 1'b1, 1'b0, a, 4'hf,
                                 ~dat);
            for (int k = 0; k < 6; k++) begin
                u_sbsc_host_model.op(k < 3 ? 3'b010 : 3'b100, 1'b0, 1'b1,
                                     k < 3, a, 4'hf, ~dat);
                if (k >= 2) begin
                    d = mem[ba(a, k - 2)];
                    `CHK("burst read", {1'b1, d}, {oe, par, dout})
                end
            end
            for (int k = 0; k < 4; k++) rd(ba(a, k));
        end
        $display("bursts done");
        complete_run();
    end
endmodule
